// file: src/wsc_dev.sv
// wsc_dev.sv: device end, receives control words in 2-wire or 3-wire form
// assumes the host keeps the mode strap static and paces the clock slowly
// limitation: a strobe rise only commits after a strobe fall seen in 3-wire mode
`timescale 1ns/1ps
`include "wsc_defs.svh"
module wsc_dev (
  input  wire logic ref_clk,
  input  wire logic rst,
  wsc_if.dev        bus,
  output logic      audio_enable,
  output logic [8:0] cfg_linvol,
  output logic [8:0] cfg_rinvol,
  output logic [8:0] cfg_hpf,
  output logic [8:0] cfg_pwr,
  output logic [8:0] cfg_fmt,
  output logic [8:0] cfg_rate,
  output logic      write_strobe
);
  typedef struct packed {
    logic [1:0]  clk_s;
    logic [1:0]  dat_s;
    logic [1:0]  cs_s;
    logic [1:0]  md_s;
    logic        clk_p;
    logic        dat_p;
    logic        cs_p;
    wsc_pkg::wsc_dev_st_t st;
    logic [3:0]  cnt;
    logic [15:0] sh;
    logic        byte2;
    logic        oe;
    logic [8:0]  r_lv;
    logic [8:0]  r_rv;
    logic [8:0]  r_hp;
    logic [8:0]  r_pw;
    logic [8:0]  r_fm;
    logic [8:0]  r_sr;
    logic [8:0]  r_ac;
    logic        wr;
    logic        armed;   // strobe seen to fall while in 3-wire mode
  } wsc_dev_state_t;
  wsc_dev_state_t s_q, s_d;

  // decoded bus events, all taken from synchronised samples
  logic clk_rise;
  logic clk_fall;
  logic start_c;
  logic stop_c;
  logic cs_rise;
  logic cs_fall;
  logic three_w;
  logic sdat;

  // writes land in the addressed register, unknown addresses fall away
  // the reset register is not kept, so writing it raises no strobe
  function automatic wsc_dev_state_t commit(input wsc_dev_state_t s, input logic [15:0] w);
    commit = s;
    commit.wr = 1'b1;
    case (w[`WSC_ADDR_MSB:`WSC_ADDR_LSB])
      `WSC_REG_LINVOL: commit.r_lv = w[`WSC_DATA_MSB:0];
      `WSC_REG_RINVOL: commit.r_rv = w[`WSC_DATA_MSB:0];
      `WSC_REG_HPF:    commit.r_hp = w[`WSC_DATA_MSB:0];
      `WSC_REG_PWR:    commit.r_pw = w[`WSC_DATA_MSB:0];
      `WSC_REG_FMT:    commit.r_fm = w[`WSC_DATA_MSB:0];
      `WSC_REG_RATE:   commit.r_sr = w[`WSC_DATA_MSB:0];
      `WSC_REG_ACT:    commit.r_ac = w[`WSC_DATA_MSB:0];
      default:         commit.wr = 1'b0;
    endcase
  endfunction : commit

  // edges are found on the second synchroniser stage only
  assign sdat     = s_q.dat_s[1];
  assign three_w  = s_q.md_s[1];
  assign clk_rise = s_q.clk_s[1] & ~s_q.clk_p;
  assign clk_fall = ~s_q.clk_s[1] & s_q.clk_p;
  assign start_c  = s_q.clk_s[1] & s_q.clk_p & s_q.dat_p & ~sdat;
  assign stop_c   = s_q.clk_s[1] & s_q.clk_p & ~s_q.dat_p & sdat;
  assign cs_rise  = s_q.cs_s[1] & ~s_q.cs_p;
  assign cs_fall  = ~s_q.cs_s[1] & s_q.cs_p;

  // device only ever pulls data low; clock is never driven
  assign bus.dev_data_oe = s_q.oe;
  assign audio_enable = s_q.r_ac[`WSC_ACT_BIT];
  // every output leaves straight from the state bank
  assign cfg_linvol = s_q.r_lv;
  assign cfg_rinvol = s_q.r_rv;
  assign cfg_hpf = s_q.r_hp;
  assign cfg_pwr = s_q.r_pw;
  assign cfg_fmt = s_q.r_fm;
  assign cfg_rate = s_q.r_sr;
  assign write_strobe = s_q.wr;

  // next state of the whole device, one pass per ref_clk
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    // a mode change clears the arming, so a strap flip cannot fake a commit
    s_d.armed = three_w & s_q.armed;
    // two-stage synchronisers on every pin; only stage two is decoded
    s_d.clk_s = {s_q.clk_s[0], bus.serial_clk};
    s_d.dat_s = {s_q.dat_s[0], bus.serial_data_line};
    s_d.cs_s = {s_q.cs_s[0], bus.latch_strobe_or_addr_select};
    s_d.md_s = {s_q.md_s[0], bus.mode_sel};
    s_d.clk_p = s_q.clk_s[1];
    s_d.dat_p = sdat;
    s_d.cs_p = s_q.cs_s[1];
    if (three_w) begin
      s_d.oe = 1'b0;
      s_d.st = wsc_pkg::WSC_D_IDLE;
      if (clk_rise) s_d.sh = {s_q.sh[14:0], sdat};
      // only a strobe that fell in this mode frames a word
      if (cs_fall) s_d.armed = 1'b1;
      if (cs_rise && s_q.armed) begin
        s_d = commit(s_d, s_q.sh);
        s_d.armed = 1'b0;
      end
    end else if (start_c || stop_c) begin
      // any start restarts, any stop idles, even mid-frame
      s_d.oe = 1'b0;
      s_d.cnt = 4'h0;
      s_d.byte2 = 1'b0;
      s_d.st = start_c ? wsc_pkg::WSC_D_ADDR : wsc_pkg::WSC_D_IDLE;
    end else begin
      // byte framing: eight rises, then an ack slot opened on the falling clock
      case (s_q.st)
        // idle and skip only wait for the next start
        wsc_pkg::WSC_D_IDLE: s_d.oe = 1'b0;
        wsc_pkg::WSC_D_SKIP: s_d.oe = 1'b0;
        wsc_pkg::WSC_D_ADDR: if (clk_rise) begin
          s_d.sh = {s_q.sh[14:0], sdat};
          s_d.cnt = s_q.cnt + 4'h1;
        end else if (clk_fall && s_q.cnt == 4'h8) begin
          s_d.cnt = 4'h0;
          // write to our address only; reads are left unanswered
          if (s_q.sh[7:1] == (s_q.cs_s[1] ? `WSC_BUS_ADDR_HIGH : `WSC_BUS_ADDR_LOW)
              && !s_q.sh[0]) begin
            s_d.oe = 1'b1;
            s_d.st = wsc_pkg::WSC_D_ACK;
          end else begin
            s_d.st = wsc_pkg::WSC_D_SKIP;
          end
        end
        wsc_pkg::WSC_D_ACK: if (clk_fall) begin
          s_d.oe = 1'b0; // ack held for one clock pulse
          if (s_q.cnt == 4'h8) begin
            s_d.st = wsc_pkg::WSC_D_IDLE;
          end else begin
            s_d.cnt = 4'h0;
            s_d.st = wsc_pkg::WSC_D_BYTE;
          end
        end
        wsc_pkg::WSC_D_BYTE: if (clk_rise) begin
          s_d.sh = {s_q.sh[14:0], sdat};
          s_d.cnt = s_q.cnt + 4'h1;
        end else if (clk_fall && s_q.cnt == 4'h8) begin
          s_d.oe = 1'b1;
          s_d.st = wsc_pkg::WSC_D_ACK;
          if (s_q.byte2) s_d = commit(s_d, s_q.sh);
          else s_d.cnt = 4'h0;
          s_d.byte2 = 1'b1;
        end
        default: s_d.st = wsc_pkg::WSC_D_IDLE;
      endcase
    end
  end

  // single register bank; reset values match the register defaults
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      // detectors start at the idle-high level, so release makes no false edge
      s_q.clk_s <= 2'b11;
      s_q.dat_s <= 2'b11;
      s_q.cs_s <= 2'b11;
      s_q.clk_p <= 1'b1;
      s_q.dat_p <= 1'b1;
      s_q.cs_p <= 1'b1;
      s_q.r_lv <= `WSC_RST_LINVOL;
      s_q.r_rv <= `WSC_RST_RINVOL;
      s_q.r_hp <= `WSC_RST_HPF;
      s_q.r_pw <= `WSC_RST_PWR;
      s_q.r_fm <= `WSC_RST_FMT;
      s_q.r_sr <= `WSC_RST_RATE;
      s_q.r_ac <= `WSC_RST_ACT;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : wsc_dev

// file: src/wsc_defs.svh
// wsc_defs.svh: constants for the write-only serial control port
// assumes inclusion by bare name from any file that needs offsets or timing
`ifndef WSC_DEFS_SVH
`define WSC_DEFS_SVH
`define WSC_WORD_BITS      16
`define WSC_ADDR_MSB       15
`define WSC_ADDR_LSB       9
`define WSC_DATA_MSB       8
`define WSC_NUM_REGS       8
`define WSC_BUS_ADDR_LOW   7'h1a
`define WSC_BUS_ADDR_HIGH  7'h1b
`define WSC_REG_LINVOL     7'h00
`define WSC_REG_RINVOL     7'h01
`define WSC_REG_HPF        7'h05
`define WSC_REG_PWR        7'h06
`define WSC_REG_FMT        7'h07
`define WSC_REG_RATE       7'h08
`define WSC_REG_ACT        7'h09
`define WSC_REG_RST        7'h0f
`define WSC_ACT_BIT        0
`define WSC_RST_LINVOL     9'h097
`define WSC_RST_RINVOL     9'h097
`define WSC_RST_HPF        9'h000
`define WSC_RST_PWR        9'h09f
`define WSC_RST_FMT        9'h00a
`define WSC_RST_RATE       9'h000
`define WSC_RST_ACT        9'h000
`define WSC_HOST_DIV       4'h8
`endif

// file: src/wsc_pkg.sv
// wsc_pkg.sv: shared types of the serial control port
// assumes the constants header is compiled alongside
package wsc_pkg;
  typedef enum logic [2:0] {
    WSC_D_IDLE = 3'b000,
    WSC_D_ADDR = 3'b001,
    WSC_D_ACK  = 3'b010,
    WSC_D_BYTE = 3'b011,
    WSC_D_SKIP = 3'b100
  } wsc_dev_st_t;
  typedef enum logic [2:0] {
    WSC_H_IDLE  = 3'b000,
    WSC_H_START = 3'b001,
    WSC_H_BIT   = 3'b010,
    WSC_H_STOP  = 3'b011,
    WSC_H_LATCH = 3'b100
  } wsc_host_st_t;
endpackage : wsc_pkg

// file: src/wsc_if.sv
// wsc_if.sv: wires between host and device of the serial control port
// assumes a pull-up on the data line; any high enable pulls it low
`timescale 1ns/1ps
interface wsc_if;
  logic serial_clk;
  logic serial_data_line;
  logic host_data_oe;
  logic dev_data_oe;
  logic latch_strobe_or_addr_select;
  logic mode_sel;
  // open-drain resolution with pull-up
  assign serial_data_line = ~(host_data_oe | dev_data_oe);
  modport dev  (input serial_clk, input serial_data_line, input latch_strobe_or_addr_select,
                input mode_sel, output dev_data_oe);
  modport host (output serial_clk, input serial_data_line, output host_data_oe,
                output latch_strobe_or_addr_select, output mode_sel);
endinterface : wsc_if

// file: src/wsc_host.sv
// wsc_host.sv: host end, sends one 16-bit control word per request
// assumes the device end sits on the same interface instance
`timescale 1ns/1ps
`include "wsc_defs.svh"
module wsc_host (
  input  wire logic ref_clk,
  input  wire logic rst,
  wsc_if.host       bus,
  input  wire logic three_wire,
  input  wire logic addr_select,
  input  wire logic req_valid,
  input  wire logic [15:0] req_word,
  output logic      req_ready,
  output logic      nack_seen
);
  typedef struct packed {
    wsc_pkg::wsc_host_st_t st;
    logic [3:0]  div;
    logic        phase;
    logic [4:0]  bitn;
    logic [26:0] sh;
    logic        clk;
    logic        oe;
    logic        strobe;
    logic        nack;
    logic        ready;
    logic [1:0]  sdi;
    logic        cs;
    logic        md;
  } wsc_host_state_t;
  wsc_host_state_t s_q, s_d;
  logic tick;
  logic acking;
  assign bus.serial_clk = s_q.clk;
  assign bus.host_data_oe = s_q.oe;
  assign bus.latch_strobe_or_addr_select = s_q.cs;
  assign bus.mode_sel = s_q.md;
  assign req_ready = s_q.ready;
  assign nack_seen = s_q.nack;
  // eight-cycle divider paces every bus phase; clock low lasts one tick, clock high two
  assign tick = (s_q.div == `WSC_HOST_DIV - 4'h1);
  // ack slots fall after bits 8, 17 and 26 of the frame
  assign acking = !three_wire && (s_q.bitn == 5'd8 || s_q.bitn == 5'd17 || s_q.bitn == 5'd26);
  always_comb begin
    s_d = s_q;
    s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
    s_d.sdi = {s_q.sdi[0], bus.serial_data_line};
    case (s_q.st)
      wsc_pkg::WSC_H_IDLE: begin
        s_d.clk = 1'b1;
        s_d.strobe = 1'b1;
        s_d.oe = 1'b0;
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.nack = 1'b0;
          s_d.bitn = 5'd0;
          s_d.phase = 1'b0;
          s_d.div = 4'h0;
          // two-wire sends address, direction and word; three-wire sends the word alone
          if (three_wire) begin
            s_d.sh = {req_word, 11'h000};
            s_d.clk = 1'b0;
            s_d.strobe = 1'b0;
            s_d.st = wsc_pkg::WSC_H_BIT;
          end else begin
            s_d.sh = {addr_select ? `WSC_BUS_ADDR_HIGH : `WSC_BUS_ADDR_LOW, 1'b0, 1'b1,
                      req_word[15:8], 1'b1, req_word[7:0], 1'b1};
            s_d.st = wsc_pkg::WSC_H_START;
          end
        end
      end
      wsc_pkg::WSC_H_START: if (tick) begin
        s_d.oe = 1'b1; // data falls while clock high
        s_d.st = wsc_pkg::WSC_H_BIT;
      end
      wsc_pkg::WSC_H_BIT: if (tick) begin
        s_d.phase = ~s_q.phase;
        if (!s_q.phase) begin
          // clock low: set up the next bit, msb first
          s_d.clk = 1'b0;
          s_d.oe = acking ? 1'b0 : ~s_q.sh[26];
        end else if (s_q.clk == 1'b0) begin
          s_d.clk = 1'b1;
          s_d.phase = 1'b1;
        end else begin
          if (acking && s_q.sdi[1]) s_d.nack = 1'b1;
          s_d.sh = {s_q.sh[25:0], 1'b1};
          s_d.bitn = s_q.bitn + 5'd1;
          s_d.phase = 1'b0;
          if ((three_wire && s_q.bitn == 5'd15) || s_q.bitn == 5'd26) begin
            s_d.st = three_wire ? wsc_pkg::WSC_H_LATCH : wsc_pkg::WSC_H_STOP;
          end
        end
      end
      wsc_pkg::WSC_H_STOP: if (tick) begin
        // drop clock, hold data low, then release with clock high
        if (s_q.clk) begin
          s_d.clk = 1'b0;
          s_d.oe = 1'b1;
        end else begin
          s_d.clk = 1'b1;
          s_d.st = wsc_pkg::WSC_H_LATCH;
        end
      end
      wsc_pkg::WSC_H_LATCH: if (tick) begin
        s_d.oe = 1'b0;
        s_d.strobe = 1'b1; // rising strobe commits the word
        s_d.clk = 1'b1;
        s_d.st = wsc_pkg::WSC_H_IDLE;
      end
      default: s_d.st = wsc_pkg::WSC_H_IDLE;
    endcase
    // pins leave from flops too; strap and address select lag one cycle
    s_d.md = three_wire;
    s_d.cs = three_wire ? s_d.strobe : addr_select;
  end
  // single register bank for the whole host state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.clk <= 1'b1;
      s_q.strobe <= 1'b1;
      s_q.sdi <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : wsc_host

// file: testbench/wsc_port_props.sv
// wsc_port_props.sv: timing checks on the wires between the host and device ends
// assumes the bench feeds it the interface signals by name
`timescale 1ns/1ps
module wsc_port_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_data_line,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic latch_strobe_or_addr_select,
  input wire logic mode_sel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // acknowledge exists only in the two-wire format
  a_ack_two_wire: assert property (mode_sel |-> !dev_data_oe)
    else $error("ack driven in three-wire mode");
  // ack starts while clock is low, so it never fakes a start
  a_ack_clk_low: assert property ($rose(dev_data_oe) |-> !serial_clk)
    else $error("ack raised with clock high");
  a_ack_held: assert property ($rose(serial_clk) && dev_data_oe |=> dev_data_oe[*4])
    else $error("ack dropped during clock high");
  // release with clock high would look like a stop
  a_ack_release: assert property ($fell(dev_data_oe) |-> !serial_clk)
    else $error("ack released with clock high");
  a_ack_host_off: assert property (serial_clk && dev_data_oe |-> !host_data_oe)
    else $error("host drove data in ack slot");
  a_ack_width: assert property ($rose(dev_data_oe) |=>
    dev_data_oe[*8] ##[1:40] !dev_data_oe)
    else $error("ack length out of range");
  // no ack may follow a start within eight ref_clk cycles
  a_start_no_ack: assert property ($fell(serial_data_line) && serial_clk && !mode_sel
    |=> (!dev_data_oe)[*8])
    else $error("ack right after start");
  // outside a frame the three-wire clock stays idle high
  a_clk_idle: assert property (mode_sel && latch_strobe_or_addr_select
    && $past(latch_strobe_or_addr_select) |-> serial_clk)
    else $error("clock moved outside frame");
endmodule : wsc_port_props

// file: testbench/write_only_serial_control_port_test.sv
// write_only_serial_control_port_test.sv: host and device joined, plus a rogue link
// assumes design sources and the checker are compiled first
`timescale 1ns/1ps
`include "wsc_defs.svh"
module write_only_serial_control_port_test;
  logic        ref_clk, rst, three_wire, addr_select, req_valid, req_ready, nack_seen;
  logic        audio_enable, write_strobe, ws2, smp;
  logic [15:0] req_word;
  logic [8:0]  cfg [6];
  logic [8:0]  exp_cfg [6] = '{`WSC_RST_LINVOL, `WSC_RST_RINVOL, `WSC_RST_HPF,
                              `WSC_RST_PWR, `WSC_RST_FMT, `WSC_RST_RATE};
  logic [6:0]  ra [6] = '{`WSC_REG_LINVOL, `WSC_REG_RINVOL, `WSC_REG_HPF,
                         `WSC_REG_PWR, `WSC_REG_FMT, `WSC_REG_RATE};
  logic [8:0]  av [3] = '{9'h001, 9'h000, 9'h1ff};
  int          fails = 0, check_count = 0, n_ws = 0, n_ws2 = 0;
  wsc_if bus ();
  wsc_if f2 ();  // bench plays a misbehaving host here

  wsc_host u_wsc_host (.ref_clk(ref_clk), .rst(rst), .bus(bus.host), .three_wire(three_wire),
    .addr_select(addr_select), .req_valid(req_valid), .req_word(req_word),
    .req_ready(req_ready), .nack_seen(nack_seen));
  wsc_dev u_wsc_dev (.ref_clk(ref_clk), .rst(rst), .bus(bus.dev), .audio_enable(audio_enable),
    .cfg_linvol(cfg[0]), .cfg_rinvol(cfg[1]), .cfg_hpf(cfg[2]), .cfg_pwr(cfg[3]),
    .cfg_fmt(cfg[4]), .cfg_rate(cfg[5]), .write_strobe(write_strobe));
  wsc_dev u_wsc_dev_2 (.ref_clk(ref_clk), .rst(rst), .bus(f2.dev), .audio_enable(),
    .cfg_linvol(), .cfg_rinvol(), .cfg_hpf(), .cfg_pwr(), .cfg_fmt(), .cfg_rate(),
    .write_strobe(ws2));
  wsc_port_props u_wsc_port_props (.ref_clk(ref_clk), .rst(rst), .serial_clk(bus.serial_clk),
    .serial_data_line(bus.serial_data_line), .host_data_oe(bus.host_data_oe),
    .dev_data_oe(bus.dev_data_oe), .mode_sel(bus.mode_sel),
    .latch_strobe_or_addr_select(bus.latch_strobe_or_addr_select));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // commit pulses counted on both devices
  always @(posedge ref_clk) begin
    if (write_strobe === 1'b1) n_ws++;
    if (ws2 === 1'b1) n_ws2++;
  end

  task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task chk_all;
    for (int i = 0; i < 6; i++) chk("cfg", exp_cfg[i], cfg[i]);
  endtask : chk_all
  // mode and address select settle before the request, device syncs the strap
  task put(input logic tw, input logic sel, input logic [6:0] a, input logic [8:0] d);
    three_wire <= tw;
    addr_select <= sel;
    repeat (8) @(posedge ref_clk);
    req_valid <= 1'b1;
    req_word <= {a, d};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
  endtask : put
  task hb;
    repeat (8) @(posedge ref_clk);
  endtask : hb
  // one bit slot on the rogue link; data line sampled at end of clock high
  task bit_out(input logic b);
    hb();
    f2.host_data_oe <= ~b;
    hb();
    f2.serial_clk <= 1'b1;
    hb();
    smp = f2.serial_data_line;
    f2.serial_clk <= 1'b0;
  endtask : bit_out
  // start, address byte, one word byte, then a stop where a byte is due
  task frame(input logic [7:0] a, input logic ack_exp);
    f2.host_data_oe <= 1'b1;
    hb();
    f2.serial_clk <= 1'b0;
    for (int k = 7; k >= 0; k--) bit_out(a[k]);
    bit_out(1'b1);
    chk("addr_ack", 9'(ack_exp), 9'(smp));
    for (int k = 7; k >= 0; k--) bit_out(k[0]);
    bit_out(1'b1);
    chk("byte_ack", 9'(ack_exp), 9'(smp));
    hb();
    f2.host_data_oe <= 1'b1;
    hb();
    f2.serial_clk <= 1'b1;
    hb();
    f2.host_data_oe <= 1'b0;
    hb();
  endtask : frame
  task test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    three_wire = 1'b0;
    addr_select = 1'b0;
    req_valid = 1'b0;
    req_word = 16'h0000;
    f2.serial_clk = 1'b1;
    f2.host_data_oe = 1'b0;
    f2.latch_strobe_or_addr_select = 1'b0;
    f2.mode_sel = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk_all();
    chk("active", 9'h000, 9'(audio_enable));
    // all six cfg registers in both formats, both bus addresses, back to back
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        exp_cfg[i] = {1'b1, 4'(i), 1'(m), 3'h5};
        put(1'(m), i[0], ra[i], exp_cfg[i]);
        chk_all();
        chk("writes", 9'(m * 6 + i + 1), 9'(n_ws));
        if (m == 0) chk("nack", 9'h000, 9'(nack_seen));
      end
    end
    foreach (av[k]) begin
      put(1'(k), 1'b0, `WSC_REG_ACT, av[k]);
      chk("active", 9'(av[k][0]), 9'(audio_enable));
    end
    put(1'b1, 1'b0, `WSC_REG_RST, 9'h000);
    put(1'b0, 1'b1, 7'h02, 9'h1ff);
    chk_all();
    chk("writes", 9'h00f, 9'(n_ws));
    frame(8'h35, 1'b1);
    frame(8'h36, 1'b1);
    frame(8'h34, 1'b0);
    chk("aborted", 9'h000, 9'(n_ws2));
    test_done();
  end
endmodule : write_only_serial_control_port_test
